// file: design/sfc_pkg.sv
// package: register map, field layout, types and constants of the flash controller
package sfc_pkg;
    localparam int CLK_NS = 100;
    localparam int SCK_HALF_NS = 400;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int LUT_SEQS = 16;
    localparam int LUT_PAIRS = 10;
    localparam int LUT_ENTRIES = LUT_SEQS * LUT_PAIRS;
    localparam int RX_DEPTH = 16;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [11:0] OFS_MODULE_CTRL = 12'h000;
    localparam logic [11:0] OFS_FLASH_ADDR = 12'h004;
    localparam logic [11:0] OFS_FLASH_ADDR_CFG = 12'h008;
    localparam logic [11:0] OFS_TOP_BASE = 12'h010;
    localparam logic [11:0] OFS_DELAY_CTRL_A = 12'h020;
    localparam logic [11:0] OFS_DELAY_STATUS = 12'h024;
    localparam logic [11:0] OFS_FLASH_TIMING = 12'h028;
    localparam logic [11:0] OFS_REG_BUS_CMD = 12'h02C;
    localparam logic [11:0] OFS_BUF_GENERIC_CFG = 12'h030;
    localparam logic [11:0] OFS_RX_DATA = 12'h040;
    localparam logic [11:0] OFS_LUT_BASE = 12'h200;
    localparam logic [11:0] OFS_LUT_END = 12'h340;
    ////////////////////////////////////////////////////////////////////////
    // module control fields
    localparam int MC_STROBE_A = 0;
    localparam int MC_STROBE_B = 1;
    localparam int MC_DDR_EN = 2;
    localparam int MC_RX_CLEAR = 3;
    localparam int MC_MODE_LSB = 4;
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_SERIAL = 2'h1;
    localparam logic [1:0] MODE_PARALLEL = 2'h2;
    // address config fields
    localparam int AC_CAS_LSB = 0;
    localparam int AC_WA = 4;
    // delay loop control fields
    localparam int DL_SLAVE_CHAIN_ENABLE = 0;
    localparam int DL_BYPASS = 1;
    localparam int DL_AUTO_UPD = 2;
    localparam int DL_UPD_REQ = 3;
    localparam int DL_ENABLE = 4;
    localparam int DL_HIGH_FREQ = 5;
    localparam int DL_COARSE_LSB = 8;
    localparam int DL_OFFSET_LSB = 12;
    localparam int DL_FINE_LSB = 16;
    localparam int DL_EXTRA_LSB = 20;
    localparam int DL_RES_LSB = 24;
    localparam int DL_REFCNT_LSB = 28;
    // timing fields
    localparam int FT_TDH_LSB = 0;
    localparam int FT_CS_SETUP_TIME_LSB = 4;
    localparam int FT_CS_HOLD_TIME_LSB = 8;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [31:0] WINDOW_TOP = 32'h1FFF_FFFF;
    localparam logic [31:0] WINDOW_BASE = 32'h0000_0000;
    localparam logic [31:0] TOP_RESET = 32'h0000_0000;
    localparam logic [3:0] SEQ_RESET = 4'h0;
    localparam logic [5:0] INS_STOP = 6'h00;
    localparam logic [5:0] INS_CMD = 6'h01;
    localparam logic [5:0] INS_ADDR = 6'h02;
    localparam logic [5:0] INS_CADDR = 6'h03;
    localparam logic [5:0] INS_DUMMY = 6'h04;
    localparam logic [5:0] INS_READ = 6'h05;
    localparam logic [5:0] INS_JMP_ON_CS = 6'h06;
    // basic read at index zero: command 03h, 24 address bits, 8 bytes
    localparam logic [15:0] LUT_RST0 = {INS_CMD, 2'h0, 8'h03};
    localparam logic [15:0] LUT_RST1 = {INS_ADDR, 2'h0, 8'h18};
    localparam logic [15:0] LUT_RST2 = {INS_READ, 2'h0, 8'h08};
    localparam logic [15:0] LUT_RST3 = {INS_STOP, 2'h0, 8'h00};
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CSS = 3'b001,
        ST_FETCH = 3'b010,
        ST_RUN = 3'b011,
        ST_CSH = 3'b100
    } sfc_state_e;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sfc_reg_req_s;
    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } sfc_mm_req_s;
    typedef struct packed {
        logic [3:0] cs;
        logic [31:0] faddr;
        logic portb;
        logic err;
    } sfc_xlate_s;
endpackage

// file: design/sfc_top.sv
// serial flash controller: registers, address mapping, delay loop, sequencer
//
// How it works
// - 24-bit mode, column width 3: bits 3..26 page, 2..0 column
// - word-addressable flag halves the byte address before flash access
// - four top-address registers map flashes; single, serial, parallel modes
// - per-port field picks pad loopback or external strobe for sampling
// - loopback: own clock returned as sampling strobe
// - external strobe: flash drives strobe, data sampled on it
// - bypass: loop off, slave chain set from coarse and offset fields
// - update bit loads slave chain and raises lock; software clears it
// - auto mode searches T/16 unit, reloads chain on every lock
// - table holds sixteen sequences of ten instruction-operand pairs
// - writing sequence index to command register starts that sequence
// - register port reaches all registers and the receive buffer
// - memory-mapped reads run the buffer generic sequence index
// - generic sequence index resets to zero, the basic read
// - writing receive clear bit empties the receive buffer
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sfc_top
    import sfc_pkg::*;
#(
    parameter int HALF_CYC = SCK_HALF_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire sfc_pkg::sfc_reg_req_s I_REG,
    output logic [31:0] O_RDATA,
    input wire sfc_pkg::sfc_mm_req_s I_MM,
    output logic O_MM_ACK,
    output logic [31:0] O_MM_RDATA,
    output logic O_SCK,
    output logic [3:0] O_CS_N,
    output logic [1:0] O_DO,
    output logic O_DO_OE,
    input wire logic [1:0] I_DI,
    input wire logic [1:0] I_DQS,
    output logic [7:0] O_SLV_DELAY,
    output logic O_BUSY
);
    import sfc_pkg::*;

    typedef struct packed {
        logic [31:0] rdata;
        logic [5:0] module_control_reg;
        logic [31:0] far;
        logic [4:0] facr;
        logic [3:0][31:0] top;
        logic [31:0] dlcr;
        logic [11:0] ftim;
        logic [3:0] cmd_seq;
        logic [3:0] bfg_seq;
        logic [LUT_ENTRIES-1:0][15:0] lut;
        logic [RX_DEPTH-1:0][31:0] rx;
        logic [3:0] rx_wp;
        logic [3:0] rx_rp;
        logic [4:0] rx_cnt;
        logic [3:0] sy1, sy2, sy3, flt, flt_prev;
        sfc_state_e st;
        logic [3:0] seq;
        logic [3:0] pair;
        logic [5:0] ins;
        logic [15:0] cnt;
        logic [31:0] sh;
        logic [31:0] rxw;
        logic [5:0] bits;
        logic [7:0] div;
        logic [3:0] cs_sel;
        logic [31:0] faddr;
        logic portb, par, from_mm, addr_err;
        logic sck;
        logic [3:0] cs_n;
        logic [1:0] dout;
        logic doe;
        logic mm_ack, mm_got;
        logic [31:0] mm_data;
        logic locked, searching, upd_prev;
        logic [7:0] search;
        logic [7:0] chain;
        logic busy;
    } sfc_st_s;

    sfc_st_s q, d;

    // system address to chip select and flash-local address
    function automatic sfc_xlate_s xlate(input logic [31:0] a,
            input logic [3:0][31:0] t, input logic [1:0] mode,
            input logic wa, input logic [3:0] cas);
        sfc_xlate_s r;
        logic [31:0] off;
        r = '0;
        off = a;
        if (a > WINDOW_TOP) begin
            r.err = 1'b1;
        end else if (mode == MODE_PARALLEL) begin
            if (a < t[0]) begin
                r.cs = 4'b0101;
            end else if (a < t[1]) begin
                r.cs = 4'b1010;
                off = a - t[0];
            end else begin
                r.err = 1'b1;
            end
            off = {1'b0, off[31:1]};
        end else if (a < t[0]) begin
            r.cs = 4'b0001;
        end else if (a < t[1]) begin
            r.cs = 4'b0010;
            off = a - t[0];
        end else if (mode == MODE_SERIAL && a < t[2]) begin
            r.cs = 4'b0100;
            off = a - t[1];
            r.portb = 1'b1;
        end else if (mode == MODE_SERIAL && a < t[3]) begin
            r.cs = 4'b1000;
            off = a - t[2];
            r.portb = 1'b1;
        end else begin
            r.err = 1'b1;
        end
        if (wa) begin
            off = {1'b0, off[31:1]};
        end
        r.faddr = off;
        r.err = r.err | (cas > 4'(LUT_PAIRS));
        return r;
    endfunction

    logic tick;
    logic [15:0] ent;
    logic [7:0] opr;
    logic [31:0] page, col;
    logic samp_loop, samp_ext, ext_sel, push, pop, start_reg, start_mm;
    sfc_xlate_s x;
    logic [7:0] lidx;

    assign tick = (q.div == 8'(HALF_CYC - 1));

    always_comb begin
        d = q;
        d.rdata = '0;
        d.mm_ack = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        start_reg = 1'b0;
        start_mm = 1'b0;
        x = '0;
        ent = '0;
        opr = '0;
        lidx = '0;
        ////////////////////////////////////////////////////////////////////
        // pin synchronisers: change taken once stages two and three agree
        d.sy1 = {I_DQS, I_DI};
        d.sy2 = q.sy1;
        d.sy3 = q.sy2;
        for (int i = 0; i < 4; i++) begin
            if (q.sy2[i] == q.sy3[i]) begin
                d.flt[i] = q.sy3[i];
            end
        end
        d.flt_prev = q.flt;
        ////////////////////////////////////////////////////////////////////
        // register writes
        if (I_REG.wr) begin
            case (I_REG.addr)
                OFS_MODULE_CTRL: d.module_control_reg = I_REG.wdata[5:0];
                OFS_FLASH_ADDR: d.far = I_REG.wdata;
                OFS_FLASH_ADDR_CFG: d.facr = I_REG.wdata[4:0];
                OFS_DELAY_CTRL_A: d.dlcr = I_REG.wdata;
                OFS_FLASH_TIMING: d.ftim = I_REG.wdata[11:0];
                OFS_REG_BUS_CMD: begin
                    d.cmd_seq = I_REG.wdata[3:0];
                    start_reg = (q.st == ST_IDLE);
                end
                OFS_BUF_GENERIC_CFG: d.bfg_seq = I_REG.wdata[3:0];
                default: begin
                    if (I_REG.addr >= OFS_TOP_BASE
                            && I_REG.addr < OFS_DELAY_CTRL_A) begin
                        d.top[I_REG.addr[3:2]] = I_REG.wdata;
                    end
                    if (I_REG.addr >= OFS_LUT_BASE
                            && I_REG.addr < OFS_LUT_END) begin
                        lidx = 8'((I_REG.addr - OFS_LUT_BASE) >> 1);
                        d.lut[lidx] = I_REG.wdata[15:0];
                        d.lut[lidx + 8'h01] = I_REG.wdata[31:16];
                    end
                end
            endcase
        end
        ////////////////////////////////////////////////////////////////////
        // register reads, data in the following cycle
        if (I_REG.rd) begin
            case (I_REG.addr)
                OFS_MODULE_CTRL: d.rdata = 32'(q.module_control_reg & 6'h37);
                OFS_FLASH_ADDR: d.rdata = q.far;
                OFS_FLASH_ADDR_CFG: d.rdata = 32'(q.facr);
                OFS_DELAY_CTRL_A: d.rdata = q.dlcr;
                OFS_DELAY_STATUS: d.rdata = {23'h0, q.rx_cnt,
                        1'b0, q.addr_err, (q.st != ST_IDLE), q.locked};
                OFS_FLASH_TIMING: d.rdata = 32'(q.ftim);
                OFS_REG_BUS_CMD: d.rdata = 32'(q.cmd_seq);
                OFS_BUF_GENERIC_CFG: d.rdata = 32'(q.bfg_seq);
                OFS_RX_DATA: begin
                    d.rdata = q.rx[q.rx_rp];
                    pop = (q.rx_cnt != 5'h00);
                end
                default: begin
                    if (I_REG.addr >= OFS_TOP_BASE
                            && I_REG.addr < OFS_DELAY_CTRL_A) begin
                        d.rdata = q.top[I_REG.addr[3:2]];
                    end
                    if (I_REG.addr >= OFS_LUT_BASE
                            && I_REG.addr < OFS_LUT_END) begin
                        lidx = 8'((I_REG.addr - OFS_LUT_BASE) >> 1);
                        d.rdata = {q.lut[lidx + 8'h01], q.lut[lidx]};
                    end
                end
            endcase
        end
        ////////////////////////////////////////////////////////////////////
        // delay loop and slave chain
        d.upd_prev = q.dlcr[DL_UPD_REQ];
        if (!q.dlcr[DL_SLAVE_CHAIN_ENABLE]) begin
            d.locked = 1'b0;
            d.searching = 1'b0;
        end else if (q.dlcr[DL_BYPASS]) begin
            d.searching = 1'b0;
            if (q.dlcr[DL_UPD_REQ] && !q.upd_prev) begin
                d.chain = {q.dlcr[DL_COARSE_LSB +: 4],
                        q.dlcr[DL_OFFSET_LSB +: 4]};
                d.locked = 1'b1;
            end
        end else if (q.dlcr[DL_ENABLE]) begin
            if (!q.locked && !q.searching) begin
                d.searching = 1'b1;
                d.search = '0;
            end else if (q.searching) begin
                d.search = q.search + 8'h01;
                if (q.search[7:4] == q.dlcr[DL_REFCNT_LSB +: 4]) begin
                    d.searching = 1'b0;
                    d.locked = 1'b1;
                    // unit step times multiple plus fine trim
                    d.chain = 8'(q.dlcr[DL_REFCNT_LSB +: 4]
                            * q.dlcr[DL_EXTRA_LSB +: 4])
                            + 8'(q.dlcr[DL_FINE_LSB +: 3]);
                end
            end
        end else begin
            d.locked = 1'b0;
            d.searching = 1'b0;
        end
        ////////////////////////////////////////////////////////////////////
        // sequencer
        ext_sel = q.portb ? q.module_control_reg[MC_STROBE_B] : q.module_control_reg[MC_STROBE_A];
        // loopback takes the bit one clock after our rise, past the sync delay
        samp_loop = !ext_sel && q.sck && (q.div == 8'h00);
        samp_ext = ext_sel && (q.flt[2] && !q.flt_prev[2] && !q.portb
                || q.flt[3] && !q.flt_prev[3] && q.portb);
        page = q.faddr >> q.facr[AC_CAS_LSB +: 4];
        col = q.faddr & ((32'h0000_0001 << q.facr[AC_CAS_LSB +: 4])
                - 32'h0000_0001);
        if (q.st != ST_IDLE && q.st != ST_FETCH) begin
            d.div = tick ? 8'h00 : q.div + 8'h01;
        end
        case (q.st)
            ST_IDLE: begin
                start_mm = I_MM.req && !start_reg && !q.mm_ack;
                if (start_reg || start_mm) begin
                    x = xlate(start_reg ? q.far : I_MM.addr, q.top,
                            q.module_control_reg[MC_MODE_LSB +: 2], q.facr[AC_WA],
                            q.facr[AC_CAS_LSB +: 4]);
                    d.addr_err = x.err;
                    d.seq = start_reg ? I_REG.wdata[3:0] : q.bfg_seq;
                    d.from_mm = start_mm;
                    d.mm_got = 1'b0;
                    d.mm_data = '0;
                    if (x.err) begin
                        d.mm_ack = start_mm;
                    end else begin
                        d.cs_sel = x.cs;
                        d.faddr = x.faddr;
                        d.portb = x.portb;
                        d.par = (q.module_control_reg[MC_MODE_LSB +: 2] == MODE_PARALLEL);
                        d.cs_n = ~x.cs;
                        d.pair = '0;
                        d.bits = '0;
                        d.div = '0;
                        d.cnt = 16'(q.ftim[FT_CS_SETUP_TIME_LSB +: 4]);
                        d.st = ST_CSS;
                    end
                end
            end
            ST_CSS: begin
                if (tick) begin
                    d.cnt = q.cnt - 16'h0001;
                    if (q.cnt == 16'h0000) begin
                        d.st = ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                ent = q.lut[8'(q.seq) * 8'(LUT_PAIRS) + 8'(q.pair)];
                opr = ent[7:0];
                d.ins = ent[15:10];
                d.pair = q.pair + 4'h1;
                d.doe = 1'b0;
                d.div = '0;
                d.st = ST_RUN;
                case (ent[15:10])
                    INS_CMD: begin
                        d.sh = {opr, 24'h0} << 1;
                        d.dout = {2{opr[7]}};
                        d.doe = 1'b1;
                        d.cnt = 16'h0008;
                    end
                    INS_ADDR, INS_CADDR: begin
                        d.sh = ((ent[15:10] == INS_ADDR) ? page : col)
                                << (6'd32 - 6'(opr));
                        d.dout = {2{d.sh[31]}};
                        d.sh = d.sh << 1;
                        d.doe = 1'b1;
                        d.cnt = 16'(opr);
                    end
                    INS_DUMMY: d.cnt = 16'(opr);
                    INS_READ: d.cnt = q.par ? 16'(opr) << 2 : 16'(opr) << 3;
                    default: begin
                        d.cnt = 16'(q.ftim[FT_CS_HOLD_TIME_LSB +: 4]);
                        d.st = ST_CSH;
                    end
                endcase
                if (q.pair == 4'(LUT_PAIRS)) begin
                    d.cnt = 16'(q.ftim[FT_CS_HOLD_TIME_LSB +: 4]);
                    d.doe = 1'b0;
                    d.st = ST_CSH;
                end else if (d.cnt == 16'h0000 && d.st == ST_RUN) begin
                    d.st = ST_FETCH;
                end
            end
            ST_RUN: begin
                if (tick) begin
                    d.sck = !q.sck;
                    if (!q.sck) begin
                        d.cnt = q.cnt - 16'h0001;
                    end else if (q.cnt == 16'h0000) begin
                        d.st = ST_FETCH;
                    end else if (q.doe) begin
                        d.dout = {2{q.sh[31]}};
                        d.sh = q.sh << 1;
                    end
                end
                if (q.ins == INS_READ && (samp_loop || samp_ext)) begin
                    d.rxw = q.par ? {q.rxw[29:0], q.flt[0], q.flt[1]}
                            : {q.rxw[30:0], q.portb ? q.flt[1] : q.flt[0]};
                    d.bits = q.bits + (q.par ? 6'h02 : 6'h01);
                    if (d.bits[5]) begin
                        d.bits = '0;
                        push = !q.from_mm;
                        if (!q.mm_got) begin
                            d.mm_data = d.rxw;
                            d.mm_got = 1'b1;
                        end
                    end
                end
            end
            ST_CSH: begin
                d.sck = 1'b0;
                d.doe = 1'b0;
                if (tick) begin
                    d.cnt = q.cnt - 16'h0001;
                    if (q.cnt == 16'h0000) begin
                        d.cs_n = '1;
                        d.st = ST_IDLE;
                        d.mm_ack = q.from_mm;
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase
        ////////////////////////////////////////////////////////////////////
        // receive buffer
        if (push) begin
            d.rx[q.rx_wp] = d.rxw;
        end
        d.rx_wp = q.rx_wp + 4'(push);
        d.rx_rp = q.rx_rp + 4'(pop);
        d.rx_cnt = q.rx_cnt + 5'(push) - 5'(pop);
        if (I_REG.wr && I_REG.addr == OFS_MODULE_CTRL
                && I_REG.wdata[MC_RX_CLEAR]) begin
            d.rx_wp = '0;
            d.rx_rp = '0;
            d.rx_cnt = '0;
        end
        d.busy = (d.st != ST_IDLE);
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            q <= '0;
            q.cs_n <= '1;
            q.st <= ST_IDLE;
            q.top <= {4{TOP_RESET}};
            q.far <= WINDOW_BASE;
            q.bfg_seq <= SEQ_RESET;
            q.lut[0] <= LUT_RST0;
            q.lut[1] <= LUT_RST1;
            q.lut[2] <= LUT_RST2;
            q.lut[3] <= LUT_RST3;
        end else begin
            q <= d;
        end
    end

    assign O_RDATA = q.rdata;
    assign O_MM_ACK = q.mm_ack;
    assign O_MM_RDATA = q.mm_data;
    assign O_SCK = q.sck;
    assign O_CS_N = q.cs_n;
    assign O_DO = q.dout;
    assign O_DO_OE = q.doe;
    assign O_SLV_DELAY = q.chain;
    assign O_BUSY = q.busy;
endmodule
`default_nettype wire

// file: bench/sfc_checker.sv
// checker: port-level timing relations of the flash controller
`timescale 1ns/1ns
`default_nettype none
module sfc_checker
    import sfc_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire sfc_pkg::sfc_reg_req_s I_REG,
    input wire logic [31:0] O_RDATA,
    input wire sfc_pkg::sfc_mm_req_s I_MM,
    input wire logic O_MM_ACK,
    input wire logic [31:0] O_MM_RDATA,
    input wire logic O_SCK,
    input wire logic [3:0] O_CS_N,
    input wire logic [1:0] O_DO,
    input wire logic O_DO_OE,
    input wire logic O_BUSY
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    sequence cmd_start;
        I_REG.wr && I_REG.addr == OFS_REG_BUS_CMD && !O_BUSY;
    endsequence
    sequence bad_read;
        O_MM_ACK && $past(I_MM.addr) > WINDOW_TOP;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    rdata_slot_a: assert property (!$past(I_REG.rd) |-> O_RDATA == 0)
        else $error("read data outside its slot");
    start_busy_a: assert property (cmd_start |=> O_BUSY)
        else $error("command write did not start");
    cs_busy_a: assert property (O_CS_N != 4'hF |-> O_BUSY)
        else $error("select active while idle");
    sck_idle_a: assert property (!O_BUSY |-> !O_SCK)
        else $error("link clock runs while idle");
    sck_frame_a: assert property ($rose(O_SCK) |-> O_CS_N != 4'hF)
        else $error("link clock outside frame");
    do_edge_a: assert property ($changed(O_DO) |-> !O_SCK)
        else $error("serial out moved with clock high");
    oe_frame_a: assert property (O_DO_OE |-> O_CS_N != 4'hF)
        else $error("serial out driven outside frame");
    ack_pulse_a: assert property (O_MM_ACK |=> !O_MM_ACK)
        else $error("mapped ack longer than one cycle");
    ack_req_a: assert property (O_MM_ACK |-> $past(I_MM.req))
        else $error("mapped ack without request");
    bad_zero_a: assert property (bad_read |-> O_MM_RDATA == 0)
        else $error("out of window read gave data");
endmodule
bind sfc_top sfc_checker i_sfc_checker(.I_CLK(I_CLK), .I_RST(I_RST),
    .I_REG(I_REG), .O_RDATA(O_RDATA), .I_MM(I_MM), .O_MM_ACK(O_MM_ACK),
    .O_MM_RDATA(O_MM_RDATA), .O_SCK(O_SCK), .O_CS_N(O_CS_N), .O_DO(O_DO),
    .O_DO_OE(O_DO_OE), .O_BUSY(O_BUSY));
`default_nettype wire

// file: bench/sfc_flash_model.sv
// partner: behavioural serial flash answering reads on the link
`timescale 1ns/1ns
`default_nettype none
module sfc_flash_model (
    input wire logic i_sck,
    input wire logic [3:0] i_cs_n,
    input wire logic [1:0] i_do,
    output logic [1:0] o_di,
    output logic [1:0] o_dqs
);
    logic [31:0] sh = '0;
    logic [63:0] dat = '0;
    logic [23:0] ad = '0;
    int n = 0;
    int st = 32;
    initial o_di = 2'b00;
    always @(posedge i_sck or posedge i_cs_n[0]) begin
        if (i_cs_n[0]) begin
            n = 0;
            st = 32;
            o_di = ~o_di; // released line shows inverse of last
        end else begin
            sh = {sh[30:0], i_do[0]};
            n++;
            if (n == 32) ad = sh[23:0];
            if (n == 8 && sh[7:0] == 8'h0B) st = 40;
        end
    end
    // data word built from the address, shifted out on falls
    always @(negedge i_sck) begin
        if (!i_cs_n[0] && n >= st) begin
            if (n == st) dat = {ad, 8'h5A, ~ad, 8'hA5};
            o_di = {2{dat[63]}};
            dat = dat << 1;
        end
    end
    assign o_dqs = {2{!i_cs_n[0] && n > st && i_sck}};
endmodule
`default_nettype wire

// file: bench/sfc_top_tb.sv
// testbench: register, mapped read and link scenarios of the flash controller
`timescale 1ns/1ns
`default_nettype none
module sfc_top_tb;
    import sfc_pkg::*;
    logic clk = 0;
    logic rst = 1;
    sfc_reg_req_s rq = '0;
    sfc_mm_req_s mm = '0;
    logic [31:0] rdata, mdata, v, a;
    logic ack, sck, doe, busy;
    logic [3:0] cs_n, c, o;
    logic [1:0] dout, di, dqs;
    logic [7:0] slv;
    logic [11:0] la;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    initial forever #50 clk = ~clk;
    sfc_top i_sfc_top(.I_CLK(clk), .I_RST(rst), .I_REG(rq), .O_RDATA(rdata),
        .I_MM(mm), .O_MM_ACK(ack), .O_MM_RDATA(mdata), .O_SCK(sck),
        .O_CS_N(cs_n), .O_DO(dout), .O_DO_OE(doe), .I_DI(di), .I_DQS(dqs),
        .O_SLV_DELAY(slv), .O_BUSY(busy));
    sfc_flash_model i_sfc_flash_model(.i_sck(sck), .i_cs_n(cs_n),
        .i_do(dout), .o_di(di), .o_dqs(dqs));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk) rq <= '{ad, d, 1'b1, 1'b0};
        @(posedge clk) rq <= '0;
    endtask
    task automatic rd(input logic [11:0] ad, output logic [31:0] d);
        @(posedge clk) rq <= '{ad, 32'h0, 1'b0, 1'b1};
        @(posedge clk) rq <= '0;
        #1 d = rdata;
    endtask
    task automatic mmrd(input logic [31:0] ad, e);
        int i;
        i = 0;
        @(posedge clk) mm <= '{1'b1, ad};
        do begin
            @(posedge clk);
            #1 i++;
        end while (ack !== 1'b1 && i < 3000);
        mm <= '0;
        chk("mapped data", e, mdata);
    endtask
    function automatic logic [31:0] ew(logic [31:0] ad, logic w, int s);
        logic [31:0] f;
        f = (w ? ad >> 1 : ad) >> s;
        return {f[23:0], 8'h5A};
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(44));
        repeat (4) @(posedge clk);
        rst <= 0;
        rd(OFS_BUF_GENERIC_CFG, v); chk("seq index", 32'h0, v);
        rd(OFS_FLASH_ADDR, v); chk("addr base", WINDOW_BASE, v);
        rd(OFS_LUT_BASE, v); chk("lut 0", {LUT_RST1, LUT_RST0}, v);
        rd(12'h100, v); chk("unmapped", 32'h0, v);
        la = OFS_LUT_BASE + 12'(4 * (20 + $urandom % 60));
        a = $urandom;
        wr(la, a); rd(la, v); chk("lut word", a, v);
        wr(OFS_DELAY_CTRL_A, 32'h0000_0003);
        c = 4'($urandom);
        o = 4'($urandom);
        wr(OFS_DELAY_CTRL_A, {16'h0, o, c, 8'h23});
        wr(OFS_DELAY_CTRL_A, {16'h0, o, c, 8'h2B});
        rd(OFS_DELAY_STATUS, v); chk("lock", 32'h1, v & 32'h1);
        chk("slave delay", {24'h0, c, o}, {24'h0, slv});
        wr(OFS_DELAY_CTRL_A, {16'h0, o, c, 8'h23});
        wr(OFS_DELAY_CTRL_A, 32'h0);
        v = {4'($urandom), 4'h0, c, 1'b0, o[2:0], 16'h0011};
        wr(OFS_DELAY_CTRL_A, v);
        repeat (300) @(posedge clk);
        rd(OFS_DELAY_STATUS, a); chk("auto lock", 32'h1, a & 32'h1);
        a = 32'(v[31:28]) * 32'(c) + 32'(o[2:0]);
        chk("auto delay", a, {24'h0, slv});
        wr(OFS_FLASH_TIMING, 32'h0000_0330);
        wr(OFS_TOP_BASE, 32'h0400_0000);
        for (int k = 0; k < 2; k++) begin
            a = (k == 1) ? $urandom & 32'h00FF_FFFF : 32'h0000_2004;
            wr(OFS_FLASH_ADDR_CFG, (k == 1) ? 32'h3 : 32'h10);
            wr(OFS_FLASH_ADDR, a);
            wr(OFS_REG_BUS_CMD, 32'h0);
            for (int i = 0; i < 3000 && (i == 0 || busy !== 1'b0); i++)
                @(posedge clk);
            rd(OFS_RX_DATA, v); chk("rx word", ew(a, k == 0, 3 * k), v);
            rd(OFS_DELAY_STATUS, v); chk("rx level", 32'h1, (v >> 4) & 32'h1F);
            wr(OFS_MODULE_CTRL, 32'h8);
            rd(OFS_DELAY_STATUS, v); chk("rx clear", 32'h0, (v >> 4) & 32'h1F);
        end
        wr(OFS_FLASH_ADDR_CFG, 32'h0);
        wr(OFS_LUT_BASE + 12'h014, {INS_ADDR, 10'h018, INS_CMD, 10'h00B});
        wr(OFS_LUT_BASE + 12'h018, {INS_READ, 10'h008, INS_DUMMY, 10'h008});
        wr(OFS_LUT_BASE + 12'h01C, 32'h0);
        for (int s = 0; s < 2; s++) begin
            wr(OFS_MODULE_CTRL, 32'(s));
            wr(OFS_BUF_GENERIC_CFG, 32'(s));
            a = $urandom & 32'h00FF_FFFF;
            mmrd(a, ew(a, 1'b0, 0));
        end
        mmrd(32'h2000_0000, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
